// ### design/draw_command_setup.sv
// drawing command setup: color and command registers, start decode, per-pixel color selection
// Behaviour
// - color registers: byte0 index/low/blue, byte1 high/green, byte2 red, byte3 reserved
// - pattern foreground used on mono pattern one bits and for fills and lines
// - pattern background used on mono pattern zero bits
// - mono image zero bits use source background, not while transparency is on
// - with transparency on, 8/16 bit color image pixels matching source foreground skip the write
// - autoexecute off: command write starts; on: last parameter write starts
// - autoexecute block transfer starts on destination coordinate write
// - clipping limits apply only while clip enable is set
// - destination format 000 8-bit, 001 16-bit, 010 24-bit, others reserved
// - draw enable zero runs the command but suppresses screen writes
// - mono source bit selects one bit per pixel or destination depth
// - image source bit takes source from host image port writes
// - transparency only for image sources; no color key at 24 bits
// - line alignment byte, word or doubleword; leftover data discarded; 11 reserved
// - first word skip drops zero to three leading bytes of first doubleword
// - 8-bit raster op; fills and lines force pattern to foreground color
// - x direction one left to right, y direction one top to bottom
// - command field: 0000 blit, 0010 fill, 0011 line, 0101 polygon, 1111 nop
// - top command bit marks 2D or 3D command
// - command word reachable at three offsets, one per drawing type
`timescale 1ns/1ps
module draw_command_setup #(
  parameter int addr_width = 16
) (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic [addr_width-1:0] avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [31:0]           avs_writedata,
  input  wire logic [3:0]            avs_byteenable,
  output logic      [31:0]           avs_readdata,
  output logic                       avs_waitrequest,
  input  wire logic                  pattern_bit,
  input  wire logic                  source_bit,
  input  wire logic [31:0]           pixel_in,
  input  wire logic                  pixel_valid,
  output logic                       command_start,
  output logic      [3:0]            command_code,
  output logic                       clip_active,
  output logic                       dim_3d,
  output logic                       x_left_to_right,
  output logic                       y_top_to_bottom,
  output logic      [7:0]            raster_op_code,
  output logic      [1:0]            line_alignment,
  output logic      [1:0]            first_word_skip,
  output logic                       format_reserved,
  output logic                       source_from_port,
  output logic                       source_is_mono,
  output logic      [31:0]           pattern_color,
  output logic      [31:0]           source_color,
  output logic                       pixel_write,
  output logic      [31:0]           port_word,
  output logic                       port_word_valid
);
  typedef enum logic [1:0] {st_idle = 2'b00, st_ack = 2'b01} bus_state_e;

  bus_state_e  state, next_state;
  logic [31:0] pattern_foreground_color, next_pat_fg;
  logic [31:0] pattern_background_color, next_pat_bg;
  logic [31:0] source_background_color, next_src_bg;
  logic [31:0] source_foreground_color, next_src_fg;
  logic [31:0] drawing_command_word, next_cmd;
  logic [31:0] rectangle_size, next_size;
  logic [31:0] destination_coordinates, next_dest;
  logic [31:0] next_readdata;
  logic        next_start, busy, next_busy;
  logic [2:0]  run_count, next_run_count;
  logic [31:0] next_port_word;
  logic        next_port_valid, next_pixel_write;
  logic [31:0] next_pattern_color, next_source_color;

  // byte enables merge into the stored word; reserved bits are masked off
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be, input logic [31:0] mask);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r & mask;
  endfunction : merge

  function automatic logic [31:0] color_at_depth(input logic [31:0] c, input logic [2:0] fmt);
    case (fmt)
      draw_setup_pkg::fmt_8:  return {24'h000000, c[7:0]};
      draw_setup_pkg::fmt_16: return {16'h0000, c[15:0]};
      default:                return c & draw_setup_pkg::color_mask;
    endcase
  endfunction : color_at_depth

  logic [3:0]  cmd_field;
  logic [2:0]  fmt;
  logic        acc, wr_hit;
  logic [15:0] a16;

  always_comb begin
    a16       = 16'(avs_address);
    cmd_field = drawing_command_word[draw_setup_pkg::cmdf_lo +: 4];
    fmt       = drawing_command_word[draw_setup_pkg::fmt_lo +: 3];
    acc       = (state == st_idle) && (avs_read || avs_write);
    // a write lands at the answering edge, so a master that gives up early changes nothing
    wr_hit    = (state == st_ack) && avs_write;
  end

  // register file and start decode
  always_comb begin
    next_state  = st_idle;
    next_pat_fg = pattern_foreground_color;
    next_pat_bg = pattern_background_color;
    next_src_bg = source_background_color;
    next_src_fg = source_foreground_color;
    next_cmd    = drawing_command_word;
    next_size   = rectangle_size;
    next_dest   = destination_coordinates;
    next_readdata   = avs_readdata;
    next_start      = 1'b0;
    next_port_word  = port_word;
    next_port_valid = 1'b0;
    if (acc) begin
      next_state = st_ack;
    end
    if (wr_hit) begin
      case (a16)
        draw_setup_pkg::off_pat_fg_blt, draw_setup_pkg::off_pat_fg_line, draw_setup_pkg::off_pat_fg_poly: begin
          next_pat_fg = merge(next_pat_fg, avs_writedata, avs_byteenable, draw_setup_pkg::color_mask);
        end
        draw_setup_pkg::off_pat_bg_blt, draw_setup_pkg::off_pat_bg_poly: begin
          next_pat_bg = merge(next_pat_bg, avs_writedata, avs_byteenable, draw_setup_pkg::color_mask);
        end
        draw_setup_pkg::off_src_bg: begin
          next_src_bg = merge(next_src_bg, avs_writedata, avs_byteenable, draw_setup_pkg::color_mask);
        end
        draw_setup_pkg::off_src_fg: begin
          next_src_fg = merge(next_src_fg, avs_writedata, avs_byteenable, draw_setup_pkg::color_mask);
        end
        draw_setup_pkg::off_cmd_blt, draw_setup_pkg::off_cmd_line, draw_setup_pkg::off_cmd_poly: begin
          next_cmd   = merge(next_cmd, avs_writedata, avs_byteenable, draw_setup_pkg::cmd_mask);
          // autoexecute clear means this write starts; a nop code never starts
          next_start = !next_cmd[draw_setup_pkg::bit_auto] &&
                       (next_cmd[draw_setup_pkg::cmdf_lo +: 4] != draw_setup_pkg::op_nop);
        end
        draw_setup_pkg::off_rect_size: begin
          next_size = merge(next_size, avs_writedata, avs_byteenable, draw_setup_pkg::size_mask);
        end
        draw_setup_pkg::off_dest_xy: begin
          next_dest  = merge(next_dest, avs_writedata, avs_byteenable, draw_setup_pkg::size_mask);
          next_start = drawing_command_word[draw_setup_pkg::bit_auto] &&
                       (cmd_field == draw_setup_pkg::op_blt || cmd_field == draw_setup_pkg::op_rect);
        end
        draw_setup_pkg::off_line_last: begin
          next_start = drawing_command_word[draw_setup_pkg::bit_auto] && cmd_field == draw_setup_pkg::op_line;
        end
        draw_setup_pkg::off_poly_last: begin
          next_start = drawing_command_word[draw_setup_pkg::bit_auto] && cmd_field == draw_setup_pkg::op_poly;
        end
        draw_setup_pkg::off_image_data: begin
          // host image data only flows while the port is the source
          next_port_word  = avs_writedata;
          next_port_valid = drawing_command_word[draw_setup_pkg::bit_img_src];
        end
        default: begin
        end
      endcase
    end
    if (acc && avs_read) begin
      case (a16)
        draw_setup_pkg::off_pat_fg_blt, draw_setup_pkg::off_pat_fg_line,
        draw_setup_pkg::off_pat_fg_poly: next_readdata = pattern_foreground_color;
        draw_setup_pkg::off_pat_bg_blt, draw_setup_pkg::off_pat_bg_poly: next_readdata = pattern_background_color;
        draw_setup_pkg::off_src_bg:    next_readdata = source_background_color;
        draw_setup_pkg::off_src_fg:    next_readdata = source_foreground_color;
        draw_setup_pkg::off_cmd_blt, draw_setup_pkg::off_cmd_line,
        draw_setup_pkg::off_cmd_poly:  next_readdata = drawing_command_word;
        draw_setup_pkg::off_rect_size: next_readdata = rectangle_size;
        draw_setup_pkg::off_dest_xy:   next_readdata = destination_coordinates;
        draw_setup_pkg::off_status:    next_readdata = {30'h0, format_reserved, busy};
        default:                       next_readdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state                    <= st_idle;
      pattern_foreground_color <= 32'h0000_0000;
      pattern_background_color <= 32'h0000_0000;
      source_background_color  <= 32'h0000_0000;
      source_foreground_color  <= 32'h0000_0000;
      drawing_command_word     <= 32'h0000_0000;
      rectangle_size           <= 32'h0000_0000;
      destination_coordinates  <= 32'h0000_0000;
      avs_readdata             <= 32'h0000_0000;
      command_start            <= 1'b0;
      port_word                <= 32'h0000_0000;
      port_word_valid          <= 1'b0;
    end else begin
      state                    <= next_state;
      pattern_foreground_color <= next_pat_fg;
      pattern_background_color <= next_pat_bg;
      source_background_color  <= next_src_bg;
      source_foreground_color  <= next_src_fg;
      drawing_command_word     <= next_cmd;
      rectangle_size           <= next_size;
      destination_coordinates  <= next_dest;
      avs_readdata             <= next_readdata;
      command_start            <= next_start;
      port_word                <= next_port_word;
      port_word_valid          <= next_port_valid;
    end
  end

  // one wait cycle: request taken in idle, answered from the ack state
  assign avs_waitrequest = (avs_read || avs_write) && (state != st_ack);

  // busy runs a short fixed time after a start; the datapath itself lies outside
  // a start while busy reloads the count; nothing here holds off a second command
  always_comb begin
    next_busy      = busy;
    next_run_count = run_count;
    if (command_start) begin
      next_busy      = 1'b1;
      next_run_count = draw_setup_pkg::run_len;
    end else if (busy) begin
      next_run_count = run_count - 3'h1;
      next_busy      = (run_count != 3'h1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy      <= 1'b0;
      run_count <= 3'h0;
    end else begin
      busy      <= next_busy;
      run_count <= next_run_count;
    end
  end

  // command word decode
  always_comb begin
    command_code     = cmd_field;
    clip_active      = drawing_command_word[draw_setup_pkg::bit_clip];
    dim_3d           = drawing_command_word[draw_setup_pkg::bit_dim];
    x_left_to_right  = drawing_command_word[draw_setup_pkg::bit_xdir];
    y_top_to_bottom  = drawing_command_word[draw_setup_pkg::bit_ydir];
    raster_op_code   = drawing_command_word[draw_setup_pkg::rop_lo +: 8];
    line_alignment   = drawing_command_word[draw_setup_pkg::aln_lo +: 2];
    first_word_skip  = drawing_command_word[draw_setup_pkg::skip_lo +: 2];
    format_reserved  = (fmt != draw_setup_pkg::fmt_8) && (fmt != draw_setup_pkg::fmt_16) &&
                       (fmt != draw_setup_pkg::fmt_24);
    source_from_port = drawing_command_word[draw_setup_pkg::bit_img_src];
    source_is_mono   = drawing_command_word[draw_setup_pkg::bit_mono_s];
  end

  // per-pixel color choice and write gating
  logic is_fill, transp, key_hit;
  always_comb begin
    is_fill = (cmd_field == draw_setup_pkg::op_rect) || (cmd_field == draw_setup_pkg::op_line) ||
              (cmd_field == draw_setup_pkg::op_poly);
    transp  = drawing_command_word[draw_setup_pkg::bit_transp] && source_from_port;
    // no key at 24 bpp: key_hit also requires the 8 or 16 bit format
    key_hit = (color_at_depth(pixel_in, fmt) == color_at_depth(source_foreground_color, fmt)) &&
              (fmt == draw_setup_pkg::fmt_8 || fmt == draw_setup_pkg::fmt_16);
    if (is_fill || pattern_bit || !drawing_command_word[draw_setup_pkg::bit_mono_p]) begin
      next_pattern_color = color_at_depth(pattern_foreground_color, fmt);
    end else begin
      next_pattern_color = color_at_depth(pattern_background_color, fmt);
    end
    if (!source_is_mono) begin
      next_source_color = color_at_depth(pixel_in, fmt);
    end else if (source_bit) begin
      next_source_color = color_at_depth(source_foreground_color, fmt);
    end else begin
      next_source_color = color_at_depth(source_background_color, fmt);
    end
    next_pixel_write = pixel_valid && drawing_command_word[draw_setup_pkg::bit_draw];
    if (transp && source_is_mono && !source_bit) begin
      next_pixel_write = 1'b0;
    end
    if (transp && !source_is_mono && key_hit) begin
      next_pixel_write = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pattern_color <= 32'h0000_0000;
      source_color  <= 32'h0000_0000;
      pixel_write   <= 1'b0;
    end else begin
      pattern_color <= next_pattern_color;
      source_color  <= next_source_color;
      pixel_write   <= next_pixel_write;
    end
  end

  // reset clears the colors to zero, and every check sleeps through reset
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_cmd_write_start: assert property (
    (wr_hit && a16 == draw_setup_pkg::off_cmd_blt && !avs_writedata[0] && avs_byteenable == 4'hf
    && avs_writedata[30:27] != 4'hf) |=> command_start) else $error("command write did not start");
  a_auto_no_start: assert property (
    (wr_hit && a16 == draw_setup_pkg::off_cmd_line && avs_writedata[0]
    && avs_byteenable[0]) |=> !command_start) else $error("autoexecute command write started");
  a_nop_no_start: assert property (
    (wr_hit && next_cmd[draw_setup_pkg::cmdf_lo +: 4] == draw_setup_pkg::op_nop) |=> !command_start)
    else $error("nop command started");
  a_dest_xy_start: assert property (
    (wr_hit && a16 == draw_setup_pkg::off_dest_xy && drawing_command_word[0]
    && cmd_field == draw_setup_pkg::op_blt) |=> command_start) else $error("blit not started by dest write");
  a_draw_off_quiet: assert property (!drawing_command_word[5] && !next_cmd[5] |=> !pixel_write)
    else $error("pixel write while draw disabled");
  a_key_skip: assert property (
    (pixel_valid && transp && !source_is_mono && fmt == draw_setup_pkg::fmt_8
    && pixel_in[7:0] == source_foreground_color[7:0]) |=> !pixel_write) else $error("keyed pixel written");
  a_mono_transp: assert property (
    (pixel_valid && transp && source_is_mono && !source_bit) |=> !pixel_write)
    else $error("mono zero bit written");
  a_fill_fg_color: assert property (
    is_fill |=> pattern_color == color_at_depth($past(pattern_foreground_color), $past(fmt)))
    else $error("fill not using foreground");
  a_mono_bg_color: assert property (
    (!is_fill && drawing_command_word[8] && !pattern_bit) |=>
    pattern_color == color_at_depth($past(pattern_background_color), $past(fmt))) else $error("bg pattern");
  a_src_bg_color: assert property (
    (source_is_mono && !source_bit) |=>
    source_color == color_at_depth($past(source_background_color), $past(fmt))) else $error("src bg");
  a_reserved_bits: assert property (
    source_foreground_color[31:24] == 8'h00 && drawing_command_word[16:14] == 3'h0)
    else $error("reserved bits set");
  a_port_gated: assert property (
    (wr_hit && a16 == draw_setup_pkg::off_image_data) |=> port_word_valid == $past(source_from_port))
    else $error("image word gating wrong");
  a_one_wait: assert property ((avs_read || avs_write) && state == st_idle |=> !avs_waitrequest)
    else $error("bus answer late");

  c_cmd_start:  cover property (command_start);
  c_key_skip:   cover property (pixel_valid && transp && key_hit);
  c_port_word:  cover property (port_word_valid);
  c_auto_start: cover property (wr_hit && a16 == draw_setup_pkg::off_dest_xy && drawing_command_word[0]);
  c_mono_bg:    cover property (pixel_valid && source_is_mono && !source_bit);
endmodule : draw_command_setup

// ### design/draw_setup_pkg.sv
// package: register map, command word fields and codes for the drawing command setup block
package draw_setup_pkg;
  localparam logic [15:0] off_pat_fg_blt   = 16'ha4f4;
  localparam logic [15:0] off_pat_fg_line  = 16'ha8f4;
  localparam logic [15:0] off_pat_fg_poly  = 16'hacf4;
  localparam logic [15:0] off_pat_bg_blt   = 16'ha4f0;
  localparam logic [15:0] off_pat_bg_poly  = 16'hacf0;
  localparam logic [15:0] off_src_bg       = 16'ha4f8;
  localparam logic [15:0] off_src_fg       = 16'ha4fc;
  localparam logic [15:0] off_cmd_blt      = 16'ha500;
  localparam logic [15:0] off_cmd_line     = 16'ha900;
  localparam logic [15:0] off_cmd_poly     = 16'had00;
  localparam logic [15:0] off_rect_size    = 16'ha504;
  localparam logic [15:0] off_dest_xy      = 16'ha50c;
  localparam logic [15:0] off_line_last    = 16'ha97c;
  localparam logic [15:0] off_poly_last    = 16'had7c;
  localparam logic [15:0] off_image_data   = 16'hb000;
  localparam logic [15:0] off_status       = 16'hb004;

  localparam logic [31:0] color_mask       = 32'h00ff_ffff;
  localparam logic [31:0] cmd_mask         = 32'hfffe_3fff;
  localparam logic [31:0] size_mask        = 32'h07ff_07ff;

  localparam int bit_auto    = 0;
  localparam int bit_clip    = 1;
  localparam int fmt_lo      = 2;
  localparam int bit_draw    = 5;
  localparam int bit_mono_s  = 6;
  localparam int bit_img_src = 7;
  localparam int bit_mono_p  = 8;
  localparam int bit_transp  = 9;
  localparam int aln_lo      = 10;
  localparam int skip_lo     = 12;
  localparam int rop_lo      = 17;
  localparam int bit_xdir    = 25;
  localparam int bit_ydir    = 26;
  localparam int cmdf_lo     = 27;
  localparam int bit_dim     = 31;

  localparam logic [2:0] fmt_8  = 3'h0;
  localparam logic [2:0] fmt_16 = 3'h1;
  localparam logic [2:0] fmt_24 = 3'h2;

  localparam logic [3:0] op_blt  = 4'h0;
  localparam logic [3:0] op_rect = 4'h2;
  localparam logic [3:0] op_line = 4'h3;
  localparam logic [3:0] op_poly = 4'h5;
  localparam logic [3:0] op_nop  = 4'hf;

  localparam logic [1:0] aln_byte  = 2'h0;
  localparam logic [1:0] aln_word  = 2'h1;
  localparam logic [1:0] aln_dword = 2'h2;

  localparam logic [2:0] run_len = 3'h4;
endpackage : draw_setup_pkg

// ### tb/host_model.sv
// host model: avalon-mm master that programs the setup registers and feeds the image port
`timescale 1ns/1ps
module host_model (
  input  wire logic        clk,
  input  wire logic        waitrequest,
  input  wire logic [31:0] readdata,
  output logic             read,
  output logic             write,
  output logic      [15:0] address,
  output logic      [31:0] writedata,
  output logic             timed_out
);
  initial begin
    read = 1'b0;
    write = 1'b0;
    address = 16'h0;
    writedata = 32'h0;
    timed_out = 1'b0;
  end
  // request held until waitrequest is sampled low or 50 cycles pass; the slave's wait is not assumed
  task automatic access(input logic wr, input logic [15:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= !wr;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    q = readdata;
    if (n >= 50) timed_out = 1'b1;
    read <= 1'b0;
    write <= 1'b0;
  endtask : access
  // 8-bit key goes in both low bytes, so any lane the compare looks at sees it
  task automatic key8(input logic [7:0] idx);
    logic [31:0] q;
    access(1'b1, draw_setup_pkg::off_src_fg, {16'h0, idx, idx}, q);
  endtask : key8
  task automatic auto_off();
    logic [31:0] q;
    access(1'b1, draw_setup_pkg::off_cmd_blt, {1'b0, draw_setup_pkg::op_nop, 27'h0}, q);
  endtask : auto_off
endmodule : host_model

// ### tb/tb.sv
// testbench: register access, command decode, start triggers, pixel color selection, image port
`timescale 1ns/1ps
module tb;
  logic        clk = 1'b0, rst_n = 1'b0, pattern_bit = 1'b0, source_bit = 1'b0, pixel_valid = 1'b0;
  logic [31:0] pixel_in = 32'h0, lfsr_state = 32'ha88332e9, rd, v, pf, pg, sf, sg;
  logic [31:0] avs_readdata, avs_writedata, pattern_color, source_color, port_word;
  logic [15:0] avs_address;
  logic [7:0]  raster_op_code;
  logic [3:0]  command_code;
  logic [1:0]  line_alignment, first_word_skip;
  logic        avs_read, avs_write, avs_waitrequest, command_start, clip_active, dim_3d, t_out;
  logic        x_left_to_right, y_top_to_bottom, format_reserved, source_from_port, source_is_mono;
  logic        pixel_write, port_word_valid;
  int          failures = 0, n_compared = 0, n_starts = 0, n_words = 0, es = 0;
  logic [31:0] read_q[$], port_q[$];
  localparam logic [15:0] offs[3] = '{draw_setup_pkg::off_cmd_blt, draw_setup_pkg::off_cmd_line,
                                      draw_setup_pkg::off_cmd_poly};
  localparam logic [15:0] lasts[3] = '{draw_setup_pkg::off_dest_xy, draw_setup_pkg::off_line_last,
                                       draw_setup_pkg::off_poly_last};
  localparam logic [3:0]  ops[3] = '{draw_setup_pkg::op_blt, draw_setup_pkg::op_line, draw_setup_pkg::op_poly};
  always #50 clk = ~clk;
  draw_command_setup u_dut (.clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest, .pattern_bit, .source_bit, .pixel_in,
    .pixel_valid, .command_start, .command_code, .clip_active, .dim_3d, .x_left_to_right,
    .y_top_to_bottom, .raster_op_code, .line_alignment, .first_word_skip, .format_reserved,
    .source_from_port, .source_is_mono, .pattern_color, .source_color, .pixel_write, .port_word,
    .port_word_valid);
  host_model u_host (.clk, .waitrequest(avs_waitrequest), .readdata(avs_readdata), .read(avs_read),
    .write(avs_write), .address(avs_address), .writedata(avs_writedata), .timed_out(t_out));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wrap_up();
    if (failures == 0 && n_compared > 0 && t_out === 1'b0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  function automatic logic [31:0] lfsr();
    lfsr_state = {lfsr_state[30:0], lfsr_state[31] ^ lfsr_state[21] ^ lfsr_state[1] ^ lfsr_state[0]};
    return lfsr_state;
  endfunction : lfsr
  function automatic logic [31:0] cw(input logic [3:0] op, input logic [9:0] lo);
    return {1'b0, op, 17'h0, lo};
  endfunction : cw
  task automatic acc(input logic wr, input logic [15:0] a, input logic [31:0] d);
    u_host.access(wr, a, d, rd);
    if (u_host.timed_out) begin
      failures++;
      wrap_up();
    end
  endtask : acc
  task automatic wr32(input logic [15:0] a, input logic [31:0] d);
    acc(1'b1, a, d);
  endtask : wr32
  task automatic rd32(input logic [15:0] a, input logic [31:0] e);
    read_q.push_back(e);
    acc(1'b0, a, 32'h0);
  endtask : rd32
  // command writes start only with autoexecute clear and a real operation code
  task automatic wrc(input logic [15:0] a, input logic [31:0] d);
    wr32(a, d);
    if (!d[0] && d[30:27] != draw_setup_pkg::op_nop) es++;
  endtask : wrc
  // the extra cycles let the engine's busy window run out before the next command
  task automatic sc();
    repeat (2) @(negedge clk);
    check(n_starts, es);
    repeat (4) @(posedge clk);
  endtask : sc
  task automatic px(input logic pb, sb, input logic [31:0] pin, ep, esc, input logic cs, ew);
    @(posedge clk);
    pattern_bit <= pb;
    source_bit <= sb;
    pixel_in <= pin;
    pixel_valid <= 1'b1;
    @(posedge clk);
    pixel_valid <= 1'b0;
    @(negedge clk);
    check(pattern_color, ep);
    if (cs) check(source_color, esc);
    check(pixel_write, ew);
  endtask : px
  always @(posedge clk) begin
    if (avs_read && avs_waitrequest === 1'b0) begin
      if (read_q.size() == 0) failures++;
      else check(avs_readdata, read_q.pop_front());
    end
    if (port_word_valid === 1'b1) begin
      n_words++;
      if (port_q.size() == 0) failures++;
      else check(port_word, port_q.pop_front());
    end
    if (command_start === 1'b1) n_starts++;
  end
  initial begin
    #10000000;
    failures++;
    wrap_up();
  end
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd32(draw_setup_pkg::off_cmd_blt, 32'h0);
    wr32(16'ha600, 32'hffffffff);
    rd32(16'ha600, 32'h0);
    pf = lfsr() & draw_setup_pkg::color_mask;
    pg = lfsr() & draw_setup_pkg::color_mask;
    sf = lfsr() & draw_setup_pkg::color_mask;
    sg = lfsr() & draw_setup_pkg::color_mask;
    wr32(draw_setup_pkg::off_pat_fg_blt, pf | 32'hff000000);
    wr32(draw_setup_pkg::off_pat_bg_blt, pg | 32'hff000000);
    wr32(draw_setup_pkg::off_src_fg, sf | 32'hff000000);
    wr32(draw_setup_pkg::off_src_bg, sg | 32'hff000000);
    rd32(draw_setup_pkg::off_pat_fg_line, pf);
    rd32(draw_setup_pkg::off_pat_bg_poly, pg);
    rd32(draw_setup_pkg::off_src_fg, sf);
    rd32(draw_setup_pkg::off_src_bg, sg);
    for (int i = 0; i < 16; i++) begin
      v = lfsr() & draw_setup_pkg::cmd_mask;
      v[30:27] = i[3:0];
      wrc(offs[i % 3], v);
      rd32(offs[(i + 1) % 3], v);
      check(command_code, v[30:27]);
      check(clip_active, v[1]);
      check(format_reserved, v[4:2] > 3'h2);
      check({source_from_port, source_is_mono}, v[7:6]);
      check({first_word_skip, line_alignment}, v[13:10]);
      check(raster_op_code, v[24:17]);
      check({dim_3d, y_top_to_bottom, x_left_to_right}, {v[31], v[26:25]});
      sc();
    end
    for (int i = 0; i < 3; i++) begin
      wrc(offs[i], cw(ops[i], 10'h021));
      sc();
      repeat (2) begin
        wr32(lasts[i], lfsr());
        es++;
        sc();
      end
    end
    u_host.auto_off();
    wr32(draw_setup_pkg::off_dest_xy, 32'h0);
    sc();
    // 16 bpp rectangle fill with the mono pattern set; zero pattern bits still give foreground; colors show at the active depth
    wrc(offs[0], cw(draw_setup_pkg::op_rect, 10'h124));
    px(1'b1, 1'b0, 32'h0, pf & 32'hffff, 32'h0, 1'b0, 1'b1);
    px(1'b0, 1'b0, 32'h0, pf & 32'hffff, 32'h0, 1'b0, 1'b1);
    wrc(offs[0], cw(draw_setup_pkg::op_blt, 10'h1e4));
    px(1'b0, 1'b1, 32'h0, pg & 32'hffff, sf & 32'hffff, 1'b1, 1'b1);
    px(1'b1, 1'b0, 32'h0, pf & 32'hffff, sg & 32'hffff, 1'b1, 1'b1);
    wrc(offs[0], cw(draw_setup_pkg::op_blt, 10'h3e4));
    px(1'b1, 1'b0, 32'h0, pf & 32'hffff, 32'h0, 1'b0, 1'b0);
    px(1'b1, 1'b1, 32'h0, pf & 32'hffff, sf & 32'hffff, 1'b1, 1'b1);
    wrc(offs[0], cw(draw_setup_pkg::op_blt, 10'h3a0));
    u_host.key8(sf[7:0]);
    px(1'b1, 1'b0, {16'h0, sf[7:0], sf[7:0]}, pf & 32'hff, 32'h0, 1'b0, 1'b0);
    px(1'b1, 1'b0, {16'h0, sf[7:0], sf[7:0]} ^ 32'h1, pf & 32'hff, 32'h0, 1'b0, 1'b1);
    wrc(offs[0], cw(draw_setup_pkg::op_blt, 10'h3a8));
    px(1'b1, 1'b0, {16'h0, sf[7:0], sf[7:0]}, pf, 32'h0, 1'b0, 1'b1);
    wrc(offs[0], cw(draw_setup_pkg::op_blt, 10'h184));
    px(1'b1, 1'b0, 32'h1, pf & 32'hffff, 32'h0, 1'b0, 1'b0);
    sc();
    wrc(offs[0], cw(draw_setup_pkg::op_nop, 10'h080));
    v = lfsr();
    port_q.push_back(v);
    wr32(draw_setup_pkg::off_image_data, v);
    repeat (3) @(negedge clk);
    check(n_words, 32'h1);
    check(read_q.size() + port_q.size(), 32'h0);
    wrap_up();
  end
endmodule : tb
